// ===== src/bpmc_cfg.svh
/*
  Constants for the bridge protection and mode control block: mode codes,
  half-bridge indices and the glitch filter length for the monitor inputs.
  Assumes it is included by bare name by the package and the design files.
*/
`ifndef BPMC_CFG_SVH
`define BPMC_CFG_SVH

`define BPMC_MODE_CBC_HB 2'h0
`define BPMC_MODE_OCL_HB 2'h1
`define BPMC_MODE_PARALLEL 2'h2
`define BPMC_MODE_COMPL 2'h3

`define BPMC_HB_A 0
`define BPMC_HB_B 1
`define BPMC_HB_C 2
`define BPMC_HB_D 3
`define BPMC_NUM_HB 4

`define BPMC_FLT_NS 8
`define BPMC_CLK_NS 4
`define BPMC_FLT_CYC ((`BPMC_FLT_NS + `BPMC_CLK_NS - 1) / `BPMC_CLK_NS)

`endif

// ===== src/bpmc_pkg.sv
/*
  Types shared by the bridge protection and mode control block.
  Assumes bpmc_cfg.svh is on the include path.
*/
`include "bpmc_cfg.svh"

package bpmc_pkg;

  typedef enum logic [1:0] {
    BPMC_MODE_CBC_HB_E = 2'h0,
    BPMC_MODE_OCL_HB_E = 2'h1,
    BPMC_MODE_PAR_E = 2'h2,
    BPMC_MODE_COMPL_E = 2'h3
  } bpmc_mode_t;

  // Gate command of one half-bridge: both low means high impedance.
  typedef struct packed {
    logic hi_on;
    logic lo_on;
  } bpmc_gate_t;

  typedef struct packed {
    logic gate_ok;
    logic logic_ok;
    logic temp_warn;
    logic temp_shut;
  } bpmc_mon_t;

endpackage : bpmc_pkg

// ===== src/bpmc_half_bridge.sv
/*
  One half-bridge channel: cycle current limit recovery and latched
  overcurrent shutdown. Assumes the drive input and overcurrent flags are
  synchronous to SYS_CLK_IN and that the parent gates outputs on faults.
*/
`timescale 1ns/10ps
`default_nettype none

module bpmc_half_bridge
  import bpmc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic drive_in,
  input wire logic latch_mode_in,
  input wire logic oc_hi_in,
  input wire logic oc_lo_in,
  input wire logic clear_in,
  output bpmc_pkg::bpmc_gate_t gate_out,
  output logic oc_latched_out
);
  import bpmc_pkg::*;

  logic drive_d_r;
  logic limit_r;
  logic limit_hi_r;
  logic latched_r;
  logic edge_seen;

  assign edge_seen = drive_in != drive_d_r;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      drive_d_r <= 1'b0;
    else
      drive_d_r <= drive_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || latch_mode_in)
    begin
      limit_r <= 1'b0;
      limit_hi_r <= 1'b0;
    end
    else if (oc_hi_in || oc_lo_in)
    begin
      limit_r <= 1'b1;
      limit_hi_r <= oc_hi_in;
    end
    // toggle recovers, pair reset rise restarts
    else if (edge_seen || clear_in)
    begin
      limit_r <= 1'b0;
      limit_hi_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      latched_r <= 1'b0;
    else if (latch_mode_in && (oc_hi_in || oc_lo_in))
      latched_r <= 1'b1;
    else if (clear_in)
      latched_r <= 1'b0;
  end

  always_comb
  begin
    gate_out.hi_on = drive_in;
    gate_out.lo_on = !drive_in;
    if (latched_r)
    begin
      gate_out.hi_on = 1'b0;
      gate_out.lo_on = 1'b0;
    end
    else if (limit_r)
    begin
      gate_out.hi_on = 1'b0;
      gate_out.lo_on = limit_hi_r;
    end
  end

  assign oc_latched_out = latched_r;

endmodule : bpmc_half_bridge

`default_nettype wire

// ===== src/bpmc_top.sv
/*
  Control and protection logic of a dual full-bridge driver: mode mapping
  of four drive inputs, pair resets, thermal and supply faults.
  Assumes all inputs are synchronous to SYS_CLK_IN and mode pins are static.
*/
// Operation
// - warning output low above warning temperature
// - shutdown temperature: all outputs off, fault
// - thermal latch cleared by both reset rises
// - power-on clear holds logic until supplies good
// - undervoltage forces outputs off and fault
// - undervoltage recovers by itself when good
// - pair reset low turns its pair off
// - pair reset low enables weak pulldown
// - pair reset rise clears pair overcurrent
// - four operating modes supported
// - modes one, two: inputs map directly
// - parallel: A drives AB, B drives CD
// - parallel: any reset low, all off
// - mode four: B, D complement A, C
// - mode four A high: AH and BL on
// - cycle limit holds driver until next period
// - limited driver recovers on toggle or pair reset rise
// - low trip: all off; high trip: low on
// - latch mode: no limit, shut until reset
`timescale 1ns/10ps
`default_nettype none
`include "bpmc_cfg.svh"

module bpmc_top
  import bpmc_pkg::*;
#(
  parameter int NUM_HB = `BPMC_NUM_HB
)
(
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [3:0] DRIVE_IN,
  input wire bpmc_pkg::bpmc_mode_t MODE_SEL_IN,
  input wire logic PAIR1_RESET_N_IN,
  input wire logic PAIR2_RESET_N_IN,
  input wire logic [3:0] OC_HI_IN,
  input wire logic [3:0] OC_LO_IN,
  input wire bpmc_pkg::bpmc_mon_t MON_IN,
  output bpmc_pkg::bpmc_gate_t [3:0] GATE_OUT,
  output logic [3:0] PULLDOWN_OUT,
  output logic FAULT_N_OUT,
  output logic OVERTEMP_WARNING_N_OUT
);
  import bpmc_pkg::*;

  if (NUM_HB != `BPMC_NUM_HB)
  begin : g_bad_count
    $error("bpmc_top serves exactly four half-bridges");
  end

  logic por_r;
  logic rst1_d_r;
  logic rst2_d_r;
  logic rise1;
  logic rise2;
  logic both_rise_seen1_r;
  logic both_rise_seen2_r;
  logic thermal_shutdown_r;
  logic supply_low_guard;
  logic par_mode;
  logic cmp_mode;
  logic latch_mode;
  logic [3:0] drv_map;
  logic [3:0] oc_hi_map;
  logic [3:0] oc_lo_map;
  logic [3:0] clr_map;
  logic [3:0] oc_latched;
  logic [3:0] pair_off;
  bpmc_gate_t [3:0] hb_gate;
  bpmc_gate_t [3:0] gate_nxt;

  // Bit i is high while the pair reset that owns half-bridge i is held low.
  function automatic logic [3:0] pair_low_mask(input logic p1_n, input logic p2_n);
    return {!p2_n, !p2_n, !p1_n, !p1_n};
  endfunction : pair_low_mask

  // A trip in either half of a pair acts on both halves, so that paired
  // bridges stay in step even while current limiting is active.
  function automatic logic [3:0] pair_merge(input logic [3:0] flags);
    logic lo_pair;
    logic hi_pair;
    lo_pair = flags[1] | flags[0];
    hi_pair = flags[3] | flags[2];
    return {hi_pair, hi_pair, lo_pair, lo_pair};
  endfunction : pair_merge

  assign par_mode = MODE_SEL_IN == BPMC_MODE_PAR_E;
  assign cmp_mode = MODE_SEL_IN == BPMC_MODE_COMPL_E;
  assign latch_mode = MODE_SEL_IN == BPMC_MODE_OCL_HB_E;

  assign supply_low_guard = !(MON_IN.gate_ok && MON_IN.logic_ok);

  // Later undervoltage does not re-arm this; the live supply gate covers it.
  // power-on clear
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      por_r <= 1'b1;
    else if (!supply_low_guard)
      por_r <= 1'b0;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      rst1_d_r <= 1'b1;
      rst2_d_r <= 1'b1;
    end
    else
    begin
      rst1_d_r <= PAIR1_RESET_N_IN;
      rst2_d_r <= PAIR2_RESET_N_IN;
    end
  end

  assign rise1 = PAIR1_RESET_N_IN && !rst1_d_r;
  assign rise2 = PAIR2_RESET_N_IN && !rst2_d_r;

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN || !thermal_shutdown_r)
    begin
      both_rise_seen1_r <= 1'b0;
      both_rise_seen2_r <= 1'b0;
    end
    else
    begin
      if (rise1)
        both_rise_seen1_r <= 1'b1;
      if (rise2)
        both_rise_seen2_r <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      thermal_shutdown_r <= 1'b0;
    else if (MON_IN.temp_shut)
      thermal_shutdown_r <= 1'b1;
    else if ((both_rise_seen1_r || rise1) && (both_rise_seen2_r || rise2))
      thermal_shutdown_r <= 1'b0;
  end

  always_comb
  begin
    drv_map = DRIVE_IN;
    oc_hi_map = OC_HI_IN;
    oc_lo_map = OC_LO_IN;
    if (par_mode)
    begin
      drv_map = {DRIVE_IN[1], DRIVE_IN[1], DRIVE_IN[0], DRIVE_IN[0]};
      oc_hi_map = pair_merge(OC_HI_IN);
      oc_lo_map = pair_merge(OC_LO_IN);
    end
    else if (cmp_mode)
    begin
      drv_map = {!DRIVE_IN[2], DRIVE_IN[2], !DRIVE_IN[0], DRIVE_IN[0]};
    end
  end

  assign clr_map = {rise2, rise2, rise1, rise1};

  for (genvar i = 0; i < 4; i++)
  begin : g_hb
    bpmc_half_bridge u_hb (
      .clk_in(SYS_CLK_IN),
      .rst_in(SYS_RST_IN || por_r),
      .drive_in(drv_map[i]),
      .latch_mode_in(latch_mode),
      .oc_hi_in(oc_hi_map[i]),
      .oc_lo_in(oc_lo_map[i]),
      .clear_in(clr_map[i]),
      .gate_out(hb_gate[i]),
      .oc_latched_out(oc_latched[i])
    );
  end

  always_comb
  begin
    pair_off = pair_low_mask(PAIR1_RESET_N_IN, PAIR2_RESET_N_IN);
    if (par_mode && !(PAIR1_RESET_N_IN && PAIR2_RESET_N_IN))
      pair_off = 4'hF;
  end

  // complement gating comes through the mapped drive
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      gate_nxt[i] = hb_gate[i];
      // The monitor is used directly so the first hot cycle is already off.
      // live shutdown and supply gating
      if (pair_off[i] || thermal_shutdown_r || MON_IN.temp_shut || supply_low_guard || por_r)
        gate_nxt[i] = '0;
    end
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      GATE_OUT <= '0;
    else
      GATE_OUT <= gate_nxt;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      PULLDOWN_OUT <= 4'h0;
    else
      PULLDOWN_OUT <= pair_low_mask(PAIR1_RESET_N_IN, PAIR2_RESET_N_IN);
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      FAULT_N_OUT <= 1'b1;
    else
      FAULT_N_OUT <= !(|oc_latched || thermal_shutdown_r || MON_IN.temp_shut
                       || supply_low_guard);
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      OVERTEMP_WARNING_N_OUT <= 1'b1;
    else
      OVERTEMP_WARNING_N_OUT <= !MON_IN.temp_warn;
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  sequence s_hot;
    MON_IN.temp_shut;
  endsequence

  sequence s_both_rise;
    rise1 && rise2;
  endsequence

  sequence s_no_fault;
    !(|oc_latched) && !thermal_shutdown_r && !MON_IN.temp_shut && !supply_low_guard;
  endsequence

  sequence s_running;
    !por_r && PAIR1_RESET_N_IN && PAIR2_RESET_N_IN;
  endsequence

  // Every output is registered, so output checks look one edge after their cause, two for the latched overcurrent fault.
  a_warn_follows_temp: assert property (
    ##1 OVERTEMP_WARNING_N_OUT == !$past(MON_IN.temp_warn))
    else $error("warning output does not follow temperature");

  a_thermal_off: assert property (s_hot |=> GATE_OUT == '0 && !FAULT_N_OUT)
    else $error("thermal shutdown did not turn outputs off");

  a_thermal_held: assert property (
    thermal_shutdown_r && !MON_IN.temp_shut && !rise1 && !rise2
    && !both_rise_seen1_r && !both_rise_seen2_r |=> thermal_shutdown_r)
    else $error("thermal latch cleared without reset rises");

  a_thermal_clear: assert property (
    s_both_rise ##0 !MON_IN.temp_shut |=> !thermal_shutdown_r)
    else $error("thermal latch not cleared by reset rises");

  a_uv_off: assert property (supply_low_guard |=> GATE_OUT == '0 && !FAULT_N_OUT)
    else $error("undervoltage did not turn outputs off");

  a_uv_recover: assert property (
    s_no_fault ##0 s_running |=> GATE_OUT == $past(hb_gate))
    else $error("outputs not resumed with supplies good");

  a_por_hold: assert property (por_r |=> GATE_OUT == '0)
    else $error("outputs active during power-on clear");

  a_pair1_off: assert property (
    !PAIR1_RESET_N_IN |=> GATE_OUT[1:0] == '0 && PULLDOWN_OUT[1:0] == 2'h3)
    else $error("pair one not off under its reset");

  a_pair2_off: assert property (
    !PAIR2_RESET_N_IN |=> GATE_OUT[3:2] == '0 && PULLDOWN_OUT[3:2] == 2'h3)
    else $error("pair two not off under its reset");

  a_pulldown_off: assert property (
    PAIR1_RESET_N_IN && PAIR2_RESET_N_IN |=> PULLDOWN_OUT == 4'h0)
    else $error("pulldown enabled with both pairs released");

  a_par_all_off: assert property (par_mode && !PAIR2_RESET_N_IN |=> GATE_OUT == '0)
    else $error("parallel mode not fully off under reset");

  a_par_pair1_off: assert property (par_mode && !PAIR1_RESET_N_IN |=> GATE_OUT == '0)
    else $error("parallel mode not fully off under first reset");

  a_par_sync: assert property (
    par_mode |=> GATE_OUT[1] == GATE_OUT[0] && GATE_OUT[3] == GATE_OUT[2])
    else $error("parallel halves out of step");

  a_compl_drive: assert property (
    cmp_mode |=> !(GATE_OUT[1].hi_on && $past(DRIVE_IN[0]))
      && !(GATE_OUT[3].hi_on && $past(DRIVE_IN[2])))
    else $error("complement half-bridge high switch on with its input high");

  a_oc_latch_fault: assert property (
    latch_mode && !por_r && (|oc_hi_map || |oc_lo_map) |-> ##2 !FAULT_N_OUT)
    else $error("latching overcurrent did not raise the fault");

  a_pair_isolated: assert property (
    rise1 && !rise2 && oc_latched[2] && !por_r |=> oc_latched[2])
    else $error("first pair reset cleared a second pair fault");

  a_fault_release: assert property (s_no_fault |=> FAULT_N_OUT)
    else $error("fault held with no fault present");

  // Per half-bridge checks share one body.
  for (genvar j = 0; j < 4; j++)
  begin : g_chk
    a_direct_drive: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      !par_mode && !cmp_mode |=> !GATE_OUT[j].hi_on || $past(DRIVE_IN[j]))
      else $error("high switch on without its own drive input");
    a_no_cross: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      !(GATE_OUT[j].hi_on && GATE_OUT[j].lo_on))
      else $error("both switches of one half-bridge on");
    a_latched_off: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      oc_latched[j] |=> GATE_OUT[j] == '0)
      else $error("latched half-bridge still driven");
  end

endmodule : bpmc_top

`default_nettype wire

// ===== verification/bpmc_mcu_model.sv
/*
  Controller model: turns requested drive levels into drive pin levels.
  Assumes requests change at the rising edge of the shared clock.
*/
`timescale 1ns/10ps
`default_nettype none

module bpmc_mcu_model
(
  input wire logic clk_in,
  input wire bpmc_pkg::bpmc_mode_t mode_in,
  input wire logic [3:0] want_in,
  output logic [3:0] drive_out
);
  import bpmc_pkg::*;
  always @(posedge clk_in)
  begin
    case (mode_in)
      BPMC_MODE_PAR_E: drive_out <= {2'h0, want_in[1:0]};
      BPMC_MODE_COMPL_E: drive_out <= {1'b0, want_in[2], 1'b0, want_in[0]};
      default: drive_out <= want_in;
    endcase
  end
endmodule : bpmc_mcu_model

`default_nettype wire

// ===== verification/testbench.sv
/*
  Self-checking bench for the bridge protection and mode control block.
  Assumes the controller model drives the drive pins, one cycle behind.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import bpmc_pkg::*;
  logic clk, rst, p1, p2, flt_n, warn_n;
  logic [3:0] want, drv, och, overcurrent_latch_mode, pd;
  bpmc_mode_t mode;
  bpmc_mon_t mon;
  bpmc_gate_t [3:0] gate;
  int num_errors, check_count, cyc, m, k;
  logic [3:0] pat [3] = '{4'h5, 4'hA, 4'h3};

  bpmc_mcu_model mcu (.clk_in(clk), .mode_in(mode), .want_in(want), .drive_out(drv));
  bpmc_top dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .DRIVE_IN(drv), .MODE_SEL_IN(mode),
    .PAIR1_RESET_N_IN(p1), .PAIR2_RESET_N_IN(p2), .OC_HI_IN(och), .OC_LO_IN(overcurrent_latch_mode),
    .MON_IN(mon), .GATE_OUT(gate), .PULLDOWN_OUT(pd), .FAULT_N_OUT(flt_n),
    .OVERTEMP_WARNING_N_OUT(warn_n));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Each gate is {hi_on, lo_on}: a high input turns on the high switch.
  function automatic logic [7:0] eg(input logic [1:0] md, input logic [3:0] d);
    logic [3:0] h;
    h = d;
    if (md == BPMC_MODE_PAR_E) h = {d[1], d[1], d[0], d[0]};
    if (md == BPMC_MODE_COMPL_E) h = {~d[2], d[2], ~d[0], d[0]};
    return {h[3], ~h[3], h[2], ~h[2], h[1], ~h[1], h[0], ~h[0]};
  endfunction : eg

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task tally_and_finish;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task st(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : st
  task dr(input logic [3:0] w);
    @(posedge clk);
    want <= w;
  endtask : dr
  task rs(input logic a, input logic b);
    @(posedge clk);
    p1 <= a;
    p2 <= b;
  endtask : rs
  task mn(input logic [3:0] v);
    @(posedge clk);
    mon <= bpmc_mon_t'(v);
  endtask : mn
  task ocp(input logic [3:0] h, input logic [3:0] l);
    @(posedge clk);
    och <= h;
    overcurrent_latch_mode <= l;
    @(posedge clk);
    och <= 4'h0;
    overcurrent_latch_mode <= 4'h0;
  endtask : ocp
  // Mode pins only change while both pairs are held off.
  task setm(input logic [1:0] v);
    @(posedge clk);
    p1 <= 1'b0;
    p2 <= 1'b0;
    mode <= bpmc_mode_t'(v);
    st(2);
    chk(gate, 8'h00);
    chk({4'h0, pd}, 8'h0F);
    rs(1'b1, 1'b1);
  endtask : setm

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    rst = 1'b1;
    p1 = 1'b0;
    p2 = 1'b0;
    want = 4'h0;
    och = 4'h0;
    overcurrent_latch_mode = 4'h0;
    mode = BPMC_MODE_CBC_HB_E;
    mon = bpmc_mon_t'(4'h0);
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    p1 <= 1'b1;
    p2 <= 1'b1;
    want <= 4'h1;
    st(4);
    chk(gate, 8'h00);
    chk({7'h0, flt_n}, 8'h00);
    mn(4'hC);
    st(4);
    chk(gate, eg(2'h0, 4'h1));
    chk({7'h0, flt_n}, 8'h01);
    for (m = 0; m < 4; m++)
    begin
      setm(m[1:0]);
      for (k = 0; k < 3; k++)
      begin
        dr(pat[k]);
        st(3);
        chk(gate, eg(m[1:0], pat[k]));
      end
      if (m == 0)
      begin
        rs(1'b0, 1'b1);
        st(2);
        chk(gate, eg(2'h0, 4'h3) & 8'hF0);
        chk({4'h0, pd}, 8'h03);
        rs(1'b1, 1'b1);
      end
      if (m == 2)
      begin
        rs(1'b1, 1'b0);
        st(2);
        chk(gate, 8'h00);
        rs(1'b1, 1'b1);
      end
    end
    setm(2'h0);
    dr(4'h1);
    st(3);
    ocp(4'h1, 4'h0);
    st(4);
    chk(gate, eg(2'h0, 4'h0));
    st(4);
    chk(gate, eg(2'h0, 4'h0));
    dr(4'h0);
    dr(4'h1);
    st(3);
    chk(gate, eg(2'h0, 4'h1));
    dr(4'h0);
    st(3);
    ocp(4'h0, 4'h1);
    st(4);
    chk(gate, eg(2'h0, 4'h0) & 8'hFC);
    dr(4'h1);
    st(3);
    chk(gate, eg(2'h0, 4'h1));
    setm(2'h1);
    dr(4'h4);
    st(3);
    ocp(4'h4, 4'h0);
    st(3);
    chk(gate, eg(2'h1, 4'h4) & 8'hCF);
    chk({7'h0, flt_n}, 8'h00);
    dr(4'h0);
    dr(4'h4);
    rs(1'b0, 1'b1);
    rs(1'b1, 1'b1);
    st(3);
    chk({7'h0, flt_n}, 8'h00);
    rs(1'b1, 1'b0);
    rs(1'b1, 1'b1);
    st(3);
    chk({7'h0, flt_n}, 8'h01);
    chk(gate, eg(2'h1, 4'h4));
    dr(4'h5);
    mn(4'hE);
    st(3);
    chk({7'h0, warn_n}, 8'h00);
    chk(gate, eg(2'h1, 4'h5));
    mn(4'hD);
    st(3);
    chk(gate, 8'h00);
    chk({7'h0, flt_n}, 8'h00);
    mn(4'hC);
    rs(1'b0, 1'b1);
    rs(1'b1, 1'b1);
    st(3);
    chk({7'h0, flt_n}, 8'h00);
    rs(1'b1, 1'b0);
    rs(1'b1, 1'b1);
    st(3);
    chk({7'h0, flt_n}, 8'h01);
    chk({7'h0, warn_n}, 8'h01);
    mn(4'h4);
    st(3);
    chk(gate, 8'h00);
    chk({7'h0, flt_n}, 8'h00);
    mn(4'hC);
    st(3);
    chk(gate, eg(2'h1, 4'h5));
    chk({7'h0, flt_n}, 8'h01);
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
